//--- dv/light_channel_result_regs_bench.sv
// Self-checking bench for the light channel result registers.
`timescale 1ns/1ns
module light_channel_result_regs_bench;
    reg         sys_clk_i = 1'b0;
    reg         srst_i = 1'b1;
    reg         result_valid_i = 1'b0;
    reg  [19:0] clear_raw_i = 20'h00000, infrared_raw_i = 20'h00000, ec = 20'h00000, ei;
    reg  [15:0] lux_i = 16'h0000, el;
    reg  [4:0]  res_bits_i = 5'h14;
    reg  [8:0]  got;
    wire        read_active_i, rd_en_i, wr_en_i, rd_valid_o;
    wire [7:0]  addr_i, wr_data_i, rd_data_o;
    wire [15:0] clear_weight_o;
    integer     num_errors = 0, samples_checked = 0, k;
    initial begin
        forever #50 sys_clk_i = ~sys_clk_i;
    end
    light_channel_result_regs u_light_channel_result_regs (
        .sys_clk_i(sys_clk_i), .srst_i(srst_i), .read_active_i(read_active_i),
        .rd_en_i(rd_en_i), .wr_en_i(wr_en_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
        .result_valid_i(result_valid_i), .clear_raw_i(clear_raw_i),
        .infrared_raw_i(infrared_raw_i), .lux_i(lux_i), .res_bits_i(res_bits_i),
        .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .clear_weight_o(clear_weight_o));
    light_host_model u_host (
        .clk_i(sys_clk_i), .rd_valid_i(rd_valid_o), .rd_data_i(rd_data_o),
        .frame_o(read_active_i), .rd_o(rd_en_i), .wr_o(wr_en_i), .addr_o(addr_i),
        .data_o(wr_data_i));
    task cmp(input [15:0] g, input [15:0] e);
        samples_checked = samples_checked + 1;
        if (g !== e) begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task check(input [7:0] a, input [7:0] e);
        u_host.access(1'b0, a, 8'h00, got);
        cmp({7'h00, got}, {8'h01, e});
    endtask
    task push(input [4:0] r, input [19:0] c, input [19:0] i, input [15:0] l);
        @(negedge sys_clk_i);
        {res_bits_i, clear_raw_i, infrared_raw_i, lux_i, result_valid_i} = {r, c, i, l, 1'b1};
        @(negedge sys_clk_i);
        result_valid_i = 1'b0;
    endtask
    task chk_all;
        check(8'h8d, {ec[3:0], 4'h0});
        check(8'h8e, ec[11:4]);
        check(8'h8f, ec[19:12]);
        check(8'h90, {ei[3:0], 4'h0});
        check(8'h91, ei[11:4]);
        check(8'h92, ei[19:12]);
        check(8'h88, el[7:0]);
        check(8'h89, el[15:8]);
    endtask
    task close_out;
        $display("mismatches %0d of %0d checks", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        {ei, el} = 36'h0;
        repeat (4) @(negedge sys_clk_i);
        srst_i = 1'b0;
        chk_all;
        check(8'h93, 8'h80);
        check(8'h94, 8'h03);
        check(8'h00, 8'h00);
        // Resolutions 20, 12 and 4 bits: the top bit must land at bit 19 every time.
        for (k = 0; k < 3; k = k + 1) begin
            push(5'h14 - 5'(8 * k), 20'habcde >> (8 * k), 20'h12345 >> (8 * k), 16'h0a0b);
            ec = 20'habcde & (20'hfffff << (8 * k));
            ei = 20'h12345 & (20'hfffff << (8 * k));
            el = 16'h0a0b;
            chk_all;
        end
        // Out-of-range resolutions clamp to 4 and 20 bits, so the top bit still lands at bit 19.
        push(5'h02, 20'h0000b, 20'h00007, 16'h0c0d);
        {ec, ei, el} = {20'hb0000, 20'h70000, 16'h0c0d};
        chk_all;
        push(5'h1f, 20'h2468a, 20'h13579, 16'h0e0f);
        {ec, ei, el} = {20'h2468a, 20'h13579, 16'h0e0f};
        chk_all;
        u_host.frame(1'b1);
        push(5'h14, 20'h13579, 20'h2468a, 16'h1111);
        check(8'h8f, ec[19:12]);
        push(5'h14, 20'hfedcb, 20'h98765, 16'h2222);
        chk_all;
        u_host.frame(1'b0);
        {ec, ei, el} = {20'hfedcb, 20'h98765, 16'h2222};
        chk_all;
        u_host.access(1'b1, 8'h8f, 8'h5a, got);
        u_host.access(1'b1, 8'h91, 8'h5a, got);
        u_host.access(1'b1, 8'h93, 8'h12, got);
        u_host.access(1'b1, 8'h94, 8'h34, got);
        cmp(clear_weight_o, 16'h3412);
        chk_all;
        check(8'h93, 8'h12);
        check(8'h94, 8'h34);
        @(negedge sys_clk_i);
        srst_i = 1'b1;
        @(negedge sys_clk_i);
        srst_i = 1'b0;
        cmp(clear_weight_o, 16'h0380);
        {ec, ei, el} = 56'h0;
        chk_all;
        close_out;
    end
endmodule

//--- dv/light_host_model.sv
// Bus host model: frames reads and drives the strobed register port.
`timescale 1ns/1ns
module light_host_model (
    input  wire       clk_i,           // Clock
    input  wire       rd_valid_i,      // Read answer
    input  wire [7:0] rd_data_i,       // Read byte
    output reg        frame_o = 1'b0,  // Read frame
    output reg        rd_o = 1'b0,     // Read strobe
    output reg        wr_o = 1'b0,     // Write strobe
    output reg  [7:0] addr_o = 8'h00,  // Offset
    output reg  [7:0] data_o = 8'h00   // Write byte
);
    task frame(input on);
        @(negedge clk_i);
        frame_o = on;
    endtask
    // Released address and data lines show the inverse so a stale value cannot pass for a held one.
    task access(input w, input [7:0] a, input [7:0] d, output [8:0] got);
        @(negedge clk_i);
        {wr_o, rd_o, addr_o, data_o} = {w, !w, a, d};
        @(negedge clk_i);
        {wr_o, rd_o, addr_o, data_o} = {2'b00, ~a, ~d};
        got = {rd_valid_i, rd_data_i};
    endtask
endmodule

//--- dv/light_result_props.sv
// Port-level assertions on the light channel result registers.
`timescale 1ns/1ns
module light_result_props (
    input wire        sys_clk_i,      // Clock
    input wire        srst_i,         // Reset
    input wire        read_active_i,  // Read frame
    input wire        rd_en_i,        // Read strobe
    input wire        wr_en_i,        // Write strobe
    input wire [7:0]  addr_i,         // Offset
    input wire [7:0]  wr_data_i,      // Write byte
    input wire [7:0]  rd_data_o,      // Read byte
    input wire        rd_valid_o,     // Read answer
    input wire [15:0] clear_weight_o  // Weight
);
    wire low_rd = rd_en_i && (addr_i == 8'h8d || addr_i == 8'h90);
    wire wr_lo  = wr_en_i && addr_i == 8'h93;
    wire wr_hi  = wr_en_i && addr_i == 8'h94;
    wire rd_hi  = rd_en_i && addr_i == 8'h94;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    chk_read_answer: assert property (rd_en_i |=> rd_valid_o) else $error("no answer");
    chk_answer_cause: assert property (!rd_en_i |=> !rd_valid_o) else $error("stray answer");
    chk_data_hold: assert property (!rd_en_i |=> $stable(rd_data_o))
        else $error("read byte moved");
    chk_low_unused: assert property (low_rd |=> rd_data_o[3:0] == 4'h0)
        else $error("low nibble set");
    chk_weight_low: assert property (wr_lo |=> clear_weight_o[7:0] == $past(wr_data_i))
        else $error("weight low not written");
    chk_weight_high: assert property (wr_hi |=> clear_weight_o[15:8] == $past(wr_data_i))
        else $error("weight high not written");
    chk_weight_keep: assert property (!wr_lo && !wr_hi |=> $stable(clear_weight_o))
        else $error("weight moved");
    chk_weight_read: assert property (rd_hi |=> rd_data_o == $past(clear_weight_o[15:8]))
        else $error("weight read wrong");
    cover property (wr_hi);
    cover property (low_rd ##1 rd_valid_o);
    cover property (rd_hi);
    cover property (read_active_i && rd_en_i ##1 rd_valid_o);
endmodule
bind light_channel_result_regs light_result_props u_props (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .read_active_i(read_active_i),
    .rd_en_i(rd_en_i), .wr_en_i(wr_en_i),
    .addr_i(addr_i), .wr_data_i(wr_data_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
    .clear_weight_o(clear_weight_o));

//--- hw/light_channel_result_regs.v
// Frozen, shadowed light channel result registers and the clear channel weight.
`timescale 1ns/1ns
`include "light_result_consts.vh"

// Behaviour
// - Clear diode result carries 4 to 20 significant bits per configured resolution.
// - Clear result is MSB-aligned in 20 bits; unused low positions are zero.
// - Infrared diode result carries 4 to 20 bits, MSB-aligned the same way.
// - Visible result bytes stay unchanged for the whole of a host read.
// - A result arriving during a host read is parked in shadow until a newer result replaces it.
// - Pending shadow values move to visible registers once no read is active; a new result in that cycle wins instead.
// - Offset 0x8d bits 7:4 hold clear result bits 3:0; bits 3:0 unused.
// - Offset 0x8e holds the clear result middle byte.
// - Offset 0x8f holds the clear result top byte, bit 7 the MSB.
// - Offset 0x90 bits 7:4 hold infrared result bits 3:0; bits 3:0 unused.
// - Offset 0x91 holds the infrared result middle byte.
// - Offset 0x92 holds the infrared result top byte, bit 7 the MSB.
// - A 16-bit weight for the clear result is kept for illuminance computation.
// - Weight low byte at 0x93, high byte at 0x94.
// - Weight low byte resets to 0x80.
// - Weight high byte resets to 0x03; all result bytes reset to 0x00.
// - Illuminance bytes at 0x88 and 0x89 freeze and shadow the same way.
module light_channel_result_regs #(
    parameter WIDTH = `RESULT_WIDTH
) (
    input  wire             sys_clk_i,      // Device clock, 10 MHz
    input  wire             srst_i,         // Synchronous reset, active high
    input  wire             read_active_i,  // High while a host read transaction runs
    input  wire             rd_en_i,        // One-cycle register read strobe
    input  wire             wr_en_i,        // One-cycle register write strobe
    input  wire [7:0]       addr_i,         // Register offset
    input  wire [7:0]       wr_data_i,      // Write data byte
    input  wire             result_valid_i, // One-cycle pulse: new conversion results
    input  wire [WIDTH-1:0] clear_raw_i,    // Right-aligned clear diode conversion
    input  wire [WIDTH-1:0] infrared_raw_i, // Right-aligned infrared diode conversion
    input  wire [15:0]      lux_i,          // Illuminance result of the same conversion
    input  wire [4:0]       res_bits_i,     // Configured resolution, 4 to 20 bits
    output reg  [7:0]       rd_data_o,      // Read data, valid the cycle after rd_en_i
    output reg              rd_valid_o,     // One-cycle pulse marking rd_data_o
    output reg  [15:0]      clear_weight_o  // Clear channel weight for lux computation
);

    wire [WIDTH-1:0] clear_aligned;
    wire [WIDTH-1:0] infrared_aligned;

    reg  [WIDTH-1:0] clear_q;
    reg  [WIDTH-1:0] clear_d;
    reg  [WIDTH-1:0] infrared_q;
    reg  [WIDTH-1:0] infrared_d;
    reg  [15:0]      lux_q;
    reg  [15:0]      lux_d;
    reg  [WIDTH-1:0] clear_shadow_q;
    reg  [WIDTH-1:0] infrared_shadow_q;
    reg  [15:0]      lux_shadow_q;
    reg              pending_q;
    reg              pending_d;
    reg  [7:0]       rd_data_d;
    reg  [15:0]      weight_d;

    // The engine delivers right-aligned values; both channels share the resolution.
    result_justify #(
        .WIDTH      (WIDTH)
    ) u_clear_justify (
        .raw_i      (clear_raw_i),
        .res_bits_i (res_bits_i),
        .aligned_o  (clear_aligned)
    );

    result_justify #(
        .WIDTH      (WIDTH)
    ) u_infrared_justify (
        .raw_i      (infrared_raw_i),
        .res_bits_i (res_bits_i),
        .aligned_o  (infrared_aligned)
    );

    // Visible registers change only outside a read. A result that arrives with a
    // pending shadow while idle is newer, so it wins over the shadow copy.
    always @* begin
        clear_d    = clear_q;
        infrared_d = infrared_q;
        lux_d      = lux_q;
        pending_d  = pending_q;
        if (read_active_i) begin
            if (result_valid_i) begin
                pending_d = 1'b1;
            end
        end else if (result_valid_i) begin
            clear_d    = clear_aligned;
            infrared_d = infrared_aligned;
            lux_d      = lux_i;
            pending_d  = 1'b0;
        end else if (pending_q) begin
            clear_d    = clear_shadow_q;
            infrared_d = infrared_shadow_q;
            lux_d      = lux_shadow_q;
            pending_d  = 1'b0;
        end
    end

    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            clear_q    <= `RESULT_RESET;
            infrared_q <= `RESULT_RESET;
            lux_q      <= `LUX_RESET;
            pending_q  <= 1'b0;
        end else begin
            clear_q    <= clear_d;
            infrared_q <= infrared_d;
            lux_q      <= lux_d;
            pending_q  <= pending_d;
        end
    end

    // Shadow keeps only the newest result caught during a read; older ones that
    // were never visible are superseded, which is what a reader would want.
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            clear_shadow_q    <= `RESULT_RESET;
            infrared_shadow_q <= `RESULT_RESET;
            lux_shadow_q      <= `LUX_RESET;
        end else if (read_active_i && result_valid_i) begin
            clear_shadow_q    <= clear_aligned;
            infrared_shadow_q <= infrared_aligned;
            lux_shadow_q      <= lux_i;
        end
    end

    // Only the weight bytes are writable; result offsets fall through untouched.
    always @* begin
        weight_d = clear_weight_o;
        if (wr_en_i) begin
            case (addr_i)
                `CLEAR_WEIGHT_LOW_ADDR: begin
                    weight_d[7:0] = wr_data_i;
                end
                `CLEAR_WEIGHT_HIGH_ADDR: begin
                    weight_d[15:8] = wr_data_i;
                end
                default: begin
                    weight_d = clear_weight_o;
                end
            endcase
        end
    end

    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            clear_weight_o <= {`CLEAR_WEIGHT_HIGH_RESET, `CLEAR_WEIGHT_LOW_RESET};
        end else begin
            clear_weight_o <= weight_d;
        end
    end

    always @* begin
        case (addr_i)
            `LUX_RESULT_LOW_ADDR: begin
                rd_data_d = lux_q[7:0];
            end
            `LUX_RESULT_HIGH_ADDR: begin
                rd_data_d = lux_q[15:8];
            end
            `CLEAR_RESULT_LOW_ADDR: begin
                rd_data_d = {clear_q[`LOW_FIELD_LSB-1:0], 4'h0};
            end
            `CLEAR_RESULT_MID_ADDR: begin
                rd_data_d = clear_q[`MID_FIELD_LSB+3:`LOW_FIELD_LSB];
            end
            `CLEAR_RESULT_HIGH_ADDR: begin
                rd_data_d = clear_q[WIDTH-1:`HIGH_FIELD_LSB-4];
            end
            `INFRARED_RESULT_LOW_ADDR: begin
                rd_data_d = {infrared_q[`LOW_FIELD_LSB-1:0], 4'h0};
            end
            `INFRARED_RESULT_MID_ADDR: begin
                rd_data_d = infrared_q[`MID_FIELD_LSB+3:`LOW_FIELD_LSB];
            end
            `INFRARED_RESULT_HIGH_ADDR: begin
                rd_data_d = infrared_q[WIDTH-1:`HIGH_FIELD_LSB-4];
            end
            `CLEAR_WEIGHT_LOW_ADDR: begin
                rd_data_d = clear_weight_o[7:0];
            end
            `CLEAR_WEIGHT_HIGH_ADDR: begin
                rd_data_d = clear_weight_o[15:8];
            end
            default: begin
                rd_data_d = `UNMAPPED_READ_VALUE;
            end
        endcase
    end

    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            rd_data_o  <= 8'h00;
            rd_valid_o <= 1'b0;
        end else begin
            rd_valid_o <= rd_en_i;
            if (rd_en_i) begin
                rd_data_o <= rd_data_d;
            end
        end
    end

endmodule

//--- hw/light_result_consts.vh
// Offsets, field positions and reset values of the light channel result registers.
`ifndef LIGHT_RESULT_CONSTS_VH
`define LIGHT_RESULT_CONSTS_VH

`define LUX_RESULT_LOW_ADDR        8'h88
`define LUX_RESULT_HIGH_ADDR       8'h89
`define CLEAR_RESULT_LOW_ADDR      8'h8d
`define CLEAR_RESULT_MID_ADDR      8'h8e
`define CLEAR_RESULT_HIGH_ADDR     8'h8f
`define INFRARED_RESULT_LOW_ADDR   8'h90
`define INFRARED_RESULT_MID_ADDR   8'h91
`define INFRARED_RESULT_HIGH_ADDR  8'h92
`define CLEAR_WEIGHT_LOW_ADDR      8'h93
`define CLEAR_WEIGHT_HIGH_ADDR     8'h94

`define RESULT_WIDTH               20
`define LOW_FIELD_LSB              4
`define MID_FIELD_LSB              8
`define HIGH_FIELD_LSB             16
`define RES_MIN_BITS               5'h04
`define RES_MAX_BITS               5'h14

`define RESULT_RESET               20'h00000
`define LUX_RESET                  16'h0000
`define CLEAR_WEIGHT_LOW_RESET     8'h80
`define CLEAR_WEIGHT_HIGH_RESET    8'h03
`define UNMAPPED_READ_VALUE        8'h00

`endif

//--- hw/result_justify.v
// Left-justifies a right-aligned conversion result of 4 to 20 bits in a 20-bit field.
`timescale 1ns/1ns
`include "light_result_consts.vh"

module result_justify #(
    parameter WIDTH = `RESULT_WIDTH
) (
    input  wire [WIDTH-1:0] raw_i,     // Right-aligned conversion value
    input  wire [4:0]       res_bits_i, // Significant bits of the conversion
    output reg  [WIDTH-1:0] aligned_o  // MSB-aligned value, low positions zero
);

    reg [4:0] bits;
    reg [4:0] shift;

    always @* begin
        bits = res_bits_i;
        // Out-of-range settings are clamped so the MSB still lands at the top.
        if (bits < `RES_MIN_BITS) begin
            bits = `RES_MIN_BITS;
        end
        if (bits > `RES_MAX_BITS) begin
            bits = `RES_MAX_BITS;
        end
        shift     = `RES_MAX_BITS - bits;
        aligned_o = raw_i << shift;
    end

endmodule
